// ==== als_defines.svh ====
// Constants for the low-speed and swing configuration block
`ifndef ALS_DEFINES_SVH
`define ALS_DEFINES_SVH

// ==========================================
// Register indices (printed offsets)
`define ALS_IDX_SRC 8'hef
`define ALS_IDX_SWING 8'hf1
`define ALS_IDX_CHA 8'hf2
`define ALS_IDX_CHB 8'hdb
`define ALS_IDX_FMT 8'hf8
`define ALS_IDX_STAT 8'hf9

// ==========================================
// Field positions and values
`define ALS_SRC_BIT 4
`define ALS_CHA_BIT 3
`define ALS_CHB_BIT 0
`define ALS_SWING_ON 2'h3
`define ALS_FMT_CMOS_BIT 0
`define ALS_FMT_TWOS_BIT 1
`define ALS_REG_RESET 8'h00

// ==========================================
// Timing and widths
`define ALS_LATENCY 16
`define ALS_CODE_W 11
`define ALS_ADDR_W 12

`endif

// ==== als_pkg.sv ====
// Types shared by the low-speed and swing configuration block
`default_nettype none

package als_pkg;
    // One converter code
    typedef logic [10:0] als_code_t;
    // Both channels taken on one clock edge
    typedef struct packed {
        als_code_t cha;
        als_code_t chb;
    } als_pair_s;
    // Effective mode controls driven to the converter core
    typedef struct packed {
        logic cha_slow;
        logic chb_slow;
        logic swing_en;
    } als_mode_s;
endpackage

`default_nettype wire

// ==== als_core.sv ====
// Converter configuration registers, mode select and sample output path
//
// Operation
// [RULE1] Source bit clear: pin level sets slow mode
// [RULE2] Source bit set: per-channel register bits rule
// [RULE3] Channel A register bit enables slow mode
// [RULE4] Host sets source bit before channel bits
// [RULE5] Swing control only on gate value 11
// [RULE6] Host writes zero to unused bits
// [RULE7] All configuration registers reset to 00h
// [RULE8] Both channels sampled on the same edge
// [RULE9] Code appears sixteen cycles after sampling
// [RULE10] Each channel result is eleven bits
// [RULE11] DDR LVDS or CMOS, offset or twos
// [RULE12] Channel B register bit, honoured via source
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "als_defines.svh"

module als_core (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sclk_level,
    input wire als_pkg::als_pair_s adc_in,
    output als_pkg::als_mode_s mode_out,
    output als_pkg::als_pair_s cmos_out,
    output als_pkg::als_code_t lvds_rise,
    output als_pkg::als_code_t lvds_fall,
    output logic cmos_sel
);

    // ==========================================
    // Register storage
    // Reset word shared by every configuration register
    localparam logic [7:0] reg_rst_word = `ALS_REG_RESET;
    logic src_r;
    logic [1:0] swing_r;
    logic cha_r;
    logic chb_r;
    logic fmt_cmos_r;
    logic fmt_twos_r;

    // ==========================================
    // Bus slave state
    logic aw_held_r;
    logic w_held_r;
    logic [11:0] waddr_r;
    logic [31:0] wdata_r;
    logic wstrb0_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic do_write;
    logic wr_hit;
    logic [31:0] rd_word;
    logic rd_hit;

    // ==========================================
    // Pin synchroniser and mode select
    logic [2:0] pin_sync_r;
    logic pin_level_r;
    logic eff_a;
    logic eff_b;
    logic swing_on;

    // ==========================================
    // Sample pipeline
    als_pkg::als_pair_s pipe_r [0:`ALS_LATENCY-1];
    als_pkg::als_pair_s fmt_pair;
    logic [4:0] fill_r;

    // Write channels are taken independently, one at a time
    assign s_axi_awready = !aw_held_r;
    assign s_axi_wready = !w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign do_write = aw_held_r && w_held_r && !bvalid_r;

    // Address and data capture, in either order
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            waddr_r <= 12'h000;
            wdata_r <= 32'h00000000;
            wstrb0_r <= 1'b0;
        end else begin
            if (s_axi_awvalid && !aw_held_r) begin
                aw_held_r <= 1'b1;
                waddr_r <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_r <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_r) begin
                w_held_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb0_r <= s_axi_wstrb[0];
            end else if (do_write) begin
                w_held_r <= 1'b0;
            end
        end
    end

    // Write decode
    always_comb begin
        if (waddr_r[11:2] == {2'h0, `ALS_IDX_SRC}) begin
            wr_hit = 1'b1;
        end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_SWING}) begin
            wr_hit = 1'b1;
        end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_CHA}) begin
            wr_hit = 1'b1;
        end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_CHB}) begin
            wr_hit = 1'b1;
        end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_FMT}) begin
            wr_hit = 1'b1;
        end else begin
            wr_hit = 1'b0;
        end
    end

    // Write response, SLVERR for unmapped or read-only words
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r <= wr_hit ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Configuration register writes; unused bits are not stored
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_r <= reg_rst_word[`ALS_SRC_BIT]; // see [RULE7]
            swing_r <= reg_rst_word[1:0];
            cha_r <= reg_rst_word[`ALS_CHA_BIT];
            chb_r <= reg_rst_word[`ALS_CHB_BIT];
            fmt_cmos_r <= reg_rst_word[`ALS_FMT_CMOS_BIT];
            fmt_twos_r <= reg_rst_word[`ALS_FMT_TWOS_BIT];
        end else if (do_write && wstrb0_r) begin
            if (waddr_r[11:2] == {2'h0, `ALS_IDX_SRC}) begin
                src_r <= wdata_r[`ALS_SRC_BIT];
            end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_SWING}) begin
                swing_r <= wdata_r[1:0];
            end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_CHA}) begin
                cha_r <= wdata_r[`ALS_CHA_BIT]; // see [RULE3]
            end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_CHB}) begin
                chb_r <= wdata_r[`ALS_CHB_BIT]; // see [RULE12]
            end else if (waddr_r[11:2] == {2'h0, `ALS_IDX_FMT}) begin
                fmt_cmos_r <= wdata_r[`ALS_FMT_CMOS_BIT];
                fmt_twos_r <= wdata_r[`ALS_FMT_TWOS_BIT];
            end
        end
    end

    // Read decode; unused bits read as zero
    always_comb begin
        rd_word = 32'h00000000;
        rd_hit = 1'b1;
        if (s_axi_araddr[11:2] == {2'h0, `ALS_IDX_SRC}) begin
            rd_word[`ALS_SRC_BIT] = src_r;
        end else if (s_axi_araddr[11:2] == {2'h0, `ALS_IDX_SWING}) begin
            rd_word[1:0] = swing_r;
        end else if (s_axi_araddr[11:2] == {2'h0, `ALS_IDX_CHA}) begin
            rd_word[`ALS_CHA_BIT] = cha_r;
        end else if (s_axi_araddr[11:2] == {2'h0, `ALS_IDX_CHB}) begin
            rd_word[`ALS_CHB_BIT] = chb_r;
        end else if (s_axi_araddr[11:2] == {2'h0, `ALS_IDX_FMT}) begin
            rd_word[`ALS_FMT_CMOS_BIT] = fmt_cmos_r;
            rd_word[`ALS_FMT_TWOS_BIT] = fmt_twos_r;
        end else if (s_axi_araddr[11:2] == {2'h0, `ALS_IDX_STAT}) begin
            rd_word[3:0] = {swing_on, pin_level_r, eff_b, eff_a};
        end else begin
            rd_hit = 1'b0;
        end
    end

    // Read channel, answer registered on the same edge that takes the address
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rresp_r <= 2'h0;
            rdata_r <= 32'h00000000;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= rd_hit ? 2'h0 : 2'h2;
            rdata_r <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Pin level through three flops; change counts when last two agree
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_sync_r <= 3'h0;
            pin_level_r <= 1'b0;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], sclk_level};
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_level_r <= pin_sync_r[2];
            end
        end
    end

    // Mode source select; host orders source bit first (see [RULE4])
    assign eff_a = src_r ? cha_r : pin_level_r; // see [RULE1] see [RULE2]
    assign eff_b = src_r ? chb_r : pin_level_r; // see [RULE12]
    assign swing_on = (swing_r == `ALS_SWING_ON); // see [RULE5]

    // Mode outputs registered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_out <= '0;
        end else begin
            mode_out <= '{cha_slow: eff_a, chb_slow: eff_b, swing_en: swing_on};
        end
    end

    // Both channels enter the pipe on the same edge (see [RULE8])
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pipe_r[0] <= '0;
        end else begin
            pipe_r[0] <= adc_in;
        end
    end

    // Delay stages, one per clock; with the output stage a code leaves 16 edges after capture
    genvar gi;
    generate
        for (gi = 1; gi < `ALS_LATENCY; gi = gi + 1) begin : g_stage
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pipe_r[gi] <= '0;
                end else begin
                    pipe_r[gi] <= pipe_r[gi-1]; // see [RULE9]
                end
            end
        end
    endgenerate

    // Offset binary or twos complement by inverting the MSB
    always_comb begin
        fmt_pair = pipe_r[`ALS_LATENCY-1];
        fmt_pair.cha[`ALS_CODE_W-1] = fmt_pair.cha[`ALS_CODE_W-1] ^ fmt_twos_r;
        fmt_pair.chb[`ALS_CODE_W-1] = fmt_pair.chb[`ALS_CODE_W-1] ^ fmt_twos_r;
    end

    // Output stage; the unselected interface holds zero
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cmos_out <= '0;
            lvds_rise <= '0;
            lvds_fall <= '0;
            cmos_sel <= 1'b0;
        end else begin
            cmos_sel <= fmt_cmos_r; // see [RULE11]
            if (fmt_cmos_r) begin
                cmos_out <= fmt_pair; // see [RULE10]
                lvds_rise <= '0;
                lvds_fall <= '0;
            end else begin
                cmos_out <= '0;
                lvds_rise <= fmt_pair.cha;
                lvds_fall <= fmt_pair.chb;
            end
        end
    end

    // Counts edges after reset until pipe and output stage hold real samples
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fill_r <= 5'h00;
        end else if (fill_r != 5'h11) begin
            fill_r <= fill_r + 5'h01;
        end
    end

    // ==========================================
    // Checks
    a_mode_pin_src: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE1]
        !src_r && $stable(src_r) |=> mode_out.cha_slow == $past(pin_level_r))
        else $error("Channel A slow mode not following pin");

    a_mode_reg_src: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE2]
        src_r |=> mode_out.chb_slow == $past(chb_r))
        else $error("Channel B slow mode not following register");

    a_cha_enable: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE3]
        src_r && cha_r |=> mode_out.cha_slow)
        else $error("Channel A slow enable ignored");

    a_swing_gate: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE5]
        swing_r != 2'h3 |=> !mode_out.swing_en)
        else $error("Swing enabled without gate value 11");

    a_reset_zero: assert property (@(posedge clk_sys) // see [RULE7]
        $rose(rst_n) |-> !src_r && swing_r == 2'h0 && !cha_r && !chb_r)
        else $error("Configuration not zero after reset");

    a_lat_cha: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE9]
        fill_r == 5'h11 && !fmt_twos_r && $stable(fmt_twos_r)
            && fmt_cmos_r && $past(fmt_cmos_r)
        |-> cmos_out.cha == $past(adc_in.cha, 17)) // Shown 16 edges on, seen one later
        else $error("Channel A code latency is not 16");

    a_same_edge: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE8]
        fill_r == 5'h11 |-> pipe_r[`ALS_LATENCY-1] == $past(adc_in, 16))
        else $error("Channels not taken on the same edge");

    a_lvds_idle: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE11]
        cmos_sel |-> lvds_rise == 11'h000 && lvds_fall == 11'h000)
        else $error("LVDS lanes driven in CMOS mode");

    a_pin_filter: assert property (@(posedge clk_sys) disable iff (!rst_n) // see [RULE1]
        $changed(pin_level_r) |-> $past(pin_sync_r[1]) == $past(pin_sync_r[2]))
        else $error("Pin level changed before two flops agreed");

    a_bresp_slot: assert property (@(posedge clk_sys) disable iff (!rst_n)
        do_write |=> s_axi_bvalid ##0 (s_axi_bvalid throughout !do_write [*1]))
        else $error("Write response missing after write");

endmodule

`default_nettype wire

// ==== als_rx_model.sv ====
// Receiver model that captures sample codes leaving the converter
`timescale 1ns/1ps
`default_nettype none

module als_rx_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic cmos_sel,
    input wire als_pkg::als_pair_s cmos_out,
    input wire als_pkg::als_code_t lvds_rise,
    input wire als_pkg::als_code_t lvds_fall,
    output als_pkg::als_pair_s rx_pair_r
);
    // =====
    // Capture the active interface, A on rising word, B on falling
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rx_pair_r <= '0;
        end else if (cmos_sel) begin
            rx_pair_r <= cmos_out;
        end else begin
            rx_pair_r <= {lvds_rise, lvds_fall};
        end
    end
endmodule

`default_nettype wire

// ==== tb_adc_low_speed_swing_config.sv ====
// Self-checking bench for the low-speed and swing configuration block
`timescale 1ns/1ps
`default_nettype none
`include "als_defines.svh"

module tb_adc_low_speed_swing_config;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sclk_level = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cmos_sel;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb = 4'hf;
    als_pkg::als_pair_s adc_in = '0;
    als_pkg::als_pair_s cmos_out, rx_pair;
    als_pkg::als_mode_s mode_out;
    als_pkg::als_code_t lvds_rise, lvds_fall;
    int n_errors = 0;
    int num_checks = 0;
    int cyc = 0;

    // =====
    // Instances
    als_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .sclk_level(sclk_level), .adc_in(adc_in),
        .mode_out(mode_out), .cmos_out(cmos_out), .lvds_rise(lvds_rise),
        .lvds_fall(lvds_fall), .cmos_sel(cmos_sel));
    als_rx_model rx (.clk_sys(clk_sys), .rst_n(rst_n), .cmos_sel(cmos_sel),
        .cmos_out(cmos_out), .lvds_rise(lvds_rise), .lvds_fall(lvds_fall),
        .rx_pair_r(rx_pair));

    // =====
    // Clock, sample source and helpers
    always #2 clk_sys = ~clk_sys;

    function automatic als_pkg::als_pair_s pat(input int c);
        pat = {11'(c * 3 + 5), 11'(c * 5 + 1)};
    endfunction

    function automatic logic [31:0] fmt(input als_pkg::als_pair_s p, input logic tw);
        fmt = {10'h0, p ^ (tw ? 22'h200400 : 22'h0)};
    endfunction

    function automatic logic [11:0] addr_of(input logic [7:0] i);
        addr_of = {2'b00, i, 2'b00};
    endfunction

    // New pair every edge; history is the cycle count itself
    always @(posedge clk_sys) begin
        adc_in <= pat(cyc);
        cyc <= cyc + 1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic complete_run;
        $display("checks=%0d errors=%0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // =====
    // Bus master tasks, each channel held until its own handshake
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        int t;
        logic aw_p, w_p;
        t = 0;
        aw_p = 1'b1;
        w_p = 1'b1;
        @(posedge clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while ((aw_p || w_p) && t < 50) begin
            @(posedge clk_sys);
            t++;
            if (aw_p && s_axi_awready) begin
                aw_p = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (w_p && s_axi_wready) begin
                w_p = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
        end
        do begin
            @(posedge clk_sys);
            t++;
        end while (s_axi_bvalid !== 1'b1 && t < 50);
        if (t >= 50) n_errors++;
        chk_resp(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        int t;
        t = 0;
        @(posedge clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            t++;
        end while (s_axi_arready !== 1'b1 && t < 50);
        s_axi_arvalid <= 1'b0;
        do begin
            @(posedge clk_sys);
            t++;
        end while (s_axi_rvalid !== 1'b1 && t < 50);
        if (t >= 50) n_errors++;
        chk_val(s_axi_rdata, ed);
        chk_resp(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
    endtask

    task automatic set_pin(input logic v);
        @(posedge clk_sys);
        sclk_level <= v;
    endtask

    // =====
    // Scenarios
    task automatic test_reset_values;
        rd_chk(addr_of(`ALS_IDX_SRC), 32'h0, 2'h0);
        rd_chk(addr_of(`ALS_IDX_SWING), 32'h0, 2'h0);
        rd_chk(addr_of(`ALS_IDX_CHA), 32'h0, 2'h0);
        rd_chk(addr_of(`ALS_IDX_CHB), 32'h0, 2'h0);
        rd_chk(addr_of(`ALS_IDX_FMT), 32'h0, 2'h0);
        rd_chk(12'h100, 32'h0, 2'h2);
        axi_write(12'h100, 32'h1, 2'h2);
        chk_val({29'h0, mode_out}, 32'h0);
    endtask

    // Strobe bit 0 low: write is answered but nothing is stored
    task automatic test_strobe;
        s_axi_wstrb <= 4'he;
        axi_write(addr_of(`ALS_IDX_SRC), 32'h10, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd_chk(addr_of(`ALS_IDX_SRC), 32'h0, 2'h0);
        axi_write(addr_of(`ALS_IDX_STAT), 32'h0, 2'h2);
    endtask

    task automatic test_pin_mode;
        set_pin(1'b1);
        tick(8);
        chk_val({29'h0, mode_out}, 32'h6);
        rd_chk(addr_of(`ALS_IDX_STAT), 32'h7, 2'h0);
        set_pin(1'b0);
        tick(8);
        chk_val({29'h0, mode_out}, 32'h0);
    endtask

    task automatic test_reg_mode;
        set_pin(1'b1);
        axi_write(addr_of(`ALS_IDX_SRC), 32'h10, 2'h0);
        tick(2);
        chk_val({29'h0, mode_out}, 32'h0);
        rd_chk(addr_of(`ALS_IDX_SRC), 32'h10, 2'h0);
        axi_write(addr_of(`ALS_IDX_CHA), 32'h08, 2'h0);
        tick(2);
        chk_val({29'h0, mode_out}, 32'h4);
        axi_write(addr_of(`ALS_IDX_CHB), 32'h01, 2'h0);
        tick(2);
        chk_val({29'h0, mode_out}, 32'h6);
        axi_write(addr_of(`ALS_IDX_CHA), 32'h00, 2'h0);
        tick(2);
        chk_val({29'h0, mode_out}, 32'h2);
        axi_write(addr_of(`ALS_IDX_CHB), 32'h00, 2'h0);
        axi_write(addr_of(`ALS_IDX_SRC), 32'h00, 2'h0);
        tick(8);
        chk_val({29'h0, mode_out}, 32'h6);
        set_pin(1'b0);
        tick(8);
    endtask

    task automatic test_swing;
        axi_write(addr_of(`ALS_IDX_SWING), 32'h3, 2'h0);
        tick(2);
        chk_val({29'h0, mode_out}, 32'h1);
        rd_chk(addr_of(`ALS_IDX_STAT), 32'h8, 2'h0);
        axi_write(addr_of(`ALS_IDX_SWING), 32'h0, 2'h0);
        tick(2);
        chk_val({29'h0, mode_out}, 32'h0);
    endtask

    // Every format and interface, four back-to-back samples each
    task automatic test_stream;
        logic [31:0] e, p;
        for (int f = 0; f < 4; f++) begin
            axi_write(addr_of(`ALS_IDX_FMT), 32'(f), 2'h0);
            tick(24);
            for (int i = 0; i < 4; i++) begin
                @(posedge clk_sys);
                #1;
                e = fmt(pat(cyc - 18), f[1]);
                p = fmt(pat(cyc - 19), f[1]);
                chk_val({10'h0, cmos_out}, f[0] ? e : 32'h0);
                chk_val({10'h0, lvds_rise, lvds_fall}, f[0] ? 32'h0 : e);
                chk_val({10'h0, rx_pair}, p);
                chk_val({31'h0, cmos_sel}, 32'(f[0]));
            end
        end
    endtask

    // =====
    // Main sequence and watchdog
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        test_reset_values;
        test_strobe;
        test_pin_mode;
        test_reg_mode;
        test_swing;
        test_stream;
        complete_run;
    end

    initial begin
        #40000;
        n_errors++;
        complete_run;
    end
endmodule

`default_nettype wire
